// ==== hdl/pdtb_defines.vh ====
`ifndef PDTB_DEFINES_VH
`define PDTB_DEFINES_VH

// Bus commands as seen on the command/byte-enable lines
`define PDTB_CMD_MRD     4'h6
`define PDTB_CMD_MWR     4'h7
`define PDTB_CMD_CRD     4'hA
`define PDTB_CMD_CWR     4'hB

// Configuration dword indexes
`define PDTB_CFG_ID      6'h00
`define PDTB_CFG_CMDST   6'h01
`define PDTB_CFG_CLASS   6'h02
`define PDTB_CFG_BAR0    6'h04
`define PDTB_CFG_INT     6'h0F

// Command and status field positions
`define PDTB_CMD_MEM_BIT  1
`define PDTB_CMD_PERR_BIT 6
`define PDTB_ST_DEVSEL    9
`define PDTB_ST_STA       11
`define PDTB_ST_DPE       15
`define PDTB_DEVSEL_MED   2'h1
`define PDTB_INT_PIN      8'h01

// Memory window: 4K bytes, dword offsets
`define PDTB_WIN_BITS    12
`define PDTB_OFF_W       10

// Bridge-local interrupt register
`define PDTB_INTREG_OFF  10'h000
`define PDTB_INTEN_BIT   0
`define PDTB_SRST_BIT    1

// Internal transfer time
`define PDTB_XFER_NS     1000
`define PDTB_CLK_NS      100
`define PDTB_TMR_W       4

`endif

// ==== hdl/pdtb_parity.v ====
`timescale 1ns/1ps

module pdtb_parity (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // Bus lines
  input  wire [31:0] ad_in,
  input  wire [3:0]  cbe_n,
  input  wire        par_in,
  input  wire [31:0] ad_out,
  input  wire        ad_oe,
  // Check request and results
  input  wire        chk,
  output reg         par_out,
  output reg         par_oe,
  output reg         perr
);

  reg calc;
  reg chk_d;

  // Parity lags its data phase by one clock
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      calc    <= 1'b0;
      chk_d   <= 1'b0;
      perr    <= 1'b0;
      par_out <= 1'b0;
      par_oe  <= 1'b0;
    end else begin
      calc    <= ^{ad_in, cbe_n};
      chk_d   <= chk;
      perr    <= chk_d & (calc != par_in);
      par_out <= ^{ad_out, cbe_n};
      par_oe  <= ad_oe;
    end
  end

endmodule // pdtb_parity

// ==== hdl/pdtb_xfer_timer.v ====
`timescale 1ns/1ps

module pdtb_xfer_timer #(
  parameter          CW     = 4,
  parameter [CW-1:0] CYCLES = 4'hA
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_b,
  // Control
  input  wire start,
  output reg  busy,
  output reg  done
);

  reg [CW-1:0] count;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= {CW{1'b0}};
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy  <= 1'b1;
        count <= CYCLES - 1'b1;
      end else if (busy) begin
        if (count == {CW{1'b0}}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule // pdtb_xfer_timer

// ==== hdl/pdtb_target.v ====
`timescale 1ns/1ps
`include "pdtb_defines.vh"

// Function
// - Claim only config and memory read/write
// - Check parity on our write data phases, flag errors
// - One memory BAR claiming a 4K window
// - End with target abort, retry, disconnect, completion
// - Interrupts only through INTA#
// - First memory read retried; initiator repeats it
// - Retry repeated read while fetch in progress
// - Idle write accepted at once, posted afterwards
// - Write retried while previous write still pending
// - Posted write pending for whole 1000ns
// - Interrupt register and soft reset live here
// - Offset zero bit 0 gates INTA# drive
// - INTA# held while interrupt cause persists
// - Soft reset leaves interrupt enable bit alone
module pdtb_target #(
  parameter [15:0] VENDOR_ID = 16'h5A5A, // Arbitrary value
  parameter [15:0] DEVICE_ID = 16'hA5A5, // Arbitrary value
  parameter [31:0] CLASS_REV = 32'hFF00_0000
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // Bus inputs
  input  wire        frame_n,
  input  wire        irdy_n,
  input  wire        idsel,
  input  wire [31:0] ad_in,
  input  wire [3:0]  cbe_n,
  input  wire        par_in,
  // Bus outputs
  output reg  [31:0] ad_out,
  output reg         ad_oe,
  output wire        par_out,
  output wire        par_oe,
  output reg         devsel_n_out,
  output reg         trdy_n_out,
  output reg         stop_n_out,
  output reg         tgt_oe,
  output wire        perr_n_out,
  output wire        perr_n_oe,
  output wire        inta_n_out,
  output reg         inta_n_oe,
  // I/O core side
  output reg  [9:0]  core_addr,
  output reg  [31:0] core_wdata,
  output reg  [3:0]  core_be,
  output reg         core_wr,
  output reg         core_rd,
  input  wire [31:0] core_rdata,
  input  wire        core_irq,
  output reg         core_srst
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DEC  = 3'h1;
  localparam [2:0] S_XFER = 3'h2;
  localparam [2:0] S_STOP = 3'h3;
  localparam [2:0] S_TURN = 3'h4;
  localparam [2:0] S_BUSY = 3'h5;
  localparam [2:0] S_ABT  = 3'h6;

  // Least time rounded up to whole clocks
  localparam integer XFER_CYC =
    (`PDTB_XFER_NS + `PDTB_CLK_NS - 1) / `PDTB_CLK_NS;

  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be_n;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        be_merge[i*8 +: 8] = be_n[i] ? old_v[i*8 +: 8] : new_v[i*8 +: 8];
      end
    end
  endfunction

  reg  [2:0]  state;
  reg  [31:0] addr;
  reg  [3:0]  cmd;
  reg         is_cfg;
  reg         tabort;
  reg         mem_en;
  reg         perr_resp;
  reg         det_perr;
  reg         sig_tabort;
  reg  [31:`PDTB_WIN_BITS] bar;
  reg  [7:0]  int_line;
  reg         int_en;
  reg         op_wr;
  reg         rd_ready;
  reg  [`PDTB_OFF_W-1:0] rd_addr;
  reg  [31:0] rd_data;
  reg         tmr_start;
  reg  [31:0] cfg_rdata;
  reg  [31:0] bar_new;
  wire        tmr_busy;
  wire        tmr_done;
  wire        perr;
  wire [15:0] cmd_word;
  wire [15:0] st_word;
  wire [`PDTB_OFF_W-1:0] off;
  wire        local_off;
  wire        pend;
  wire        cfg_hit;
  wire        mem_hit;
  wire        chk;

  assign off       = addr[`PDTB_WIN_BITS-1:2];
  assign local_off = (off == `PDTB_INTREG_OFF);
  // Start, busy and done together close every gap in the pending window
  assign pend      = tmr_start | tmr_busy | tmr_done;
  assign cfg_hit   = idsel && ad_in[1:0] == 2'b00 &&
                     (cbe_n == `PDTB_CMD_CRD || cbe_n == `PDTB_CMD_CWR);
  assign mem_hit   = mem_en && ad_in[31:`PDTB_WIN_BITS] == bar &&
                     (cbe_n == `PDTB_CMD_MRD || cbe_n == `PDTB_CMD_MWR);
  assign chk       = state == S_XFER && !irdy_n && cmd[0];
  assign perr_n_out = 1'b0;
  assign perr_n_oe  = perr & perr_resp;
  assign inta_n_out = 1'b0;

  assign cmd_word = ({15'h0000, mem_en} << `PDTB_CMD_MEM_BIT) |
                    ({15'h0000, perr_resp} << `PDTB_CMD_PERR_BIT);
  assign st_word  = ({15'h0000, det_perr} << `PDTB_ST_DPE) |
                    ({15'h0000, sig_tabort} << `PDTB_ST_STA) |
                    ({14'h0000, `PDTB_DEVSEL_MED} << `PDTB_ST_DEVSEL);

  always @* begin
    cfg_rdata = 32'h0000_0000;
    case (addr[7:2])
      `PDTB_CFG_ID:    cfg_rdata = {DEVICE_ID, VENDOR_ID};
      `PDTB_CFG_CMDST: cfg_rdata = {st_word, cmd_word};
      `PDTB_CFG_CLASS: cfg_rdata = CLASS_REV;
      `PDTB_CFG_BAR0:  cfg_rdata = {bar, {`PDTB_WIN_BITS{1'b0}}};
      `PDTB_CFG_INT:   cfg_rdata = {16'h0000, `PDTB_INT_PIN, int_line};
      default:         cfg_rdata = 32'h0000_0000;
    endcase
    bar_new = be_merge({bar, {`PDTB_WIN_BITS{1'b0}}}, ad_in, cbe_n);
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= S_IDLE;
      addr         <= 32'h0000_0000;
      cmd          <= 4'h0;
      is_cfg       <= 1'b0;
      tabort       <= 1'b0;
      mem_en       <= 1'b0;
      perr_resp    <= 1'b0;
      det_perr     <= 1'b0;
      sig_tabort   <= 1'b0;
      bar          <= {(32-`PDTB_WIN_BITS){1'b0}};
      int_line     <= 8'h00;
      int_en       <= 1'b0;
      op_wr        <= 1'b0;
      rd_ready     <= 1'b0;
      rd_addr      <= {`PDTB_OFF_W{1'b0}};
      rd_data      <= 32'h0000_0000;
      tmr_start    <= 1'b0;
      ad_out       <= 32'h0000_0000;
      ad_oe        <= 1'b0;
      devsel_n_out <= 1'b1;
      trdy_n_out   <= 1'b1;
      stop_n_out   <= 1'b1;
      tgt_oe       <= 1'b0;
      inta_n_oe    <= 1'b0;
      core_addr    <= {`PDTB_OFF_W{1'b0}};
      core_wdata   <= 32'h0000_0000;
      core_be      <= 4'h0;
      core_wr      <= 1'b0;
      core_rd      <= 1'b0;
      core_srst    <= 1'b0;
    end else begin
      tmr_start <= 1'b0;
      core_wr   <= 1'b0;
      core_rd   <= 1'b0;
      core_srst <= 1'b0;
      // Follows the core's cause level, so it holds until cleared
      inta_n_oe <= int_en & core_irq;
      if (tmr_done && !op_wr) begin
        rd_ready <= 1'b1;
        rd_data  <= (core_addr == `PDTB_INTREG_OFF) ?
                    ({31'h0, int_en} << `PDTB_INTEN_BIT) : core_rdata;
      end
      case (state)
        S_IDLE: begin
          if (!frame_n) begin
            addr   <= ad_in;
            cmd    <= cbe_n;
            is_cfg <= cfg_hit;
            // Only linear burst order is supported in memory space
            tabort <= mem_hit && !cfg_hit && ad_in[1:0] != 2'b00;
            state  <= (cfg_hit || mem_hit) ? S_DEC : S_BUSY;
          end
        end
        S_DEC: begin
          tgt_oe       <= 1'b1;
          devsel_n_out <= 1'b0;
          // Stop rides with data so bursts disconnect after one dword
          if (tabort) begin
            state <= S_ABT;
          end else if (is_cfg) begin
            trdy_n_out <= 1'b0;
            stop_n_out <= 1'b0;
            ad_out     <= cfg_rdata;
            ad_oe      <= !cmd[0];
            state      <= S_XFER;
          end else if (pend) begin
            stop_n_out <= 1'b0;
            state      <= S_STOP;
          end else if (cmd[0]) begin
            trdy_n_out <= 1'b0;
            stop_n_out <= 1'b0;
            state      <= S_XFER;
          end else if (rd_ready && rd_addr == off) begin
            trdy_n_out <= 1'b0;
            stop_n_out <= 1'b0;
            ad_out     <= rd_data;
            ad_oe      <= 1'b1;
            state      <= S_XFER;
          end else begin
            rd_ready   <= 1'b0;
            rd_addr    <= off;
            core_addr  <= off;
            core_rd    <= !local_off;
            op_wr      <= 1'b0;
            tmr_start  <= 1'b1;
            stop_n_out <= 1'b0;
            state      <= S_STOP;
          end
        end
        S_ABT: begin
          devsel_n_out <= 1'b1;
          stop_n_out   <= 1'b0;
          sig_tabort   <= 1'b1;
          state        <= S_STOP;
        end
        S_XFER: begin
          if (!irdy_n) begin
            trdy_n_out <= 1'b1;
            ad_oe      <= 1'b0;
            if (is_cfg && cmd[0]) begin
              case (addr[7:2])
                `PDTB_CFG_CMDST: begin
                  if (!cbe_n[0]) begin
                    mem_en    <= ad_in[`PDTB_CMD_MEM_BIT];
                    perr_resp <= ad_in[`PDTB_CMD_PERR_BIT];
                  end
                  if (!cbe_n[3] && ad_in[16 + `PDTB_ST_DPE])
                    det_perr <= 1'b0;
                  if (!cbe_n[3] && ad_in[16 + `PDTB_ST_STA])
                    sig_tabort <= 1'b0;
                end
                `PDTB_CFG_BAR0: bar <= bar_new[31:`PDTB_WIN_BITS];
                `PDTB_CFG_INT: if (!cbe_n[0]) int_line <= ad_in[7:0];
                default: ;
              endcase
            end else if (cmd[0]) begin
              // Posted; stale read data is dropped so reads see the write
              core_addr  <= off;
              core_wdata <= ad_in;
              core_be    <= ~cbe_n;
              core_wr    <= !local_off;
              op_wr      <= 1'b1;
              tmr_start  <= 1'b1;
              rd_ready   <= 1'b0;
              if (local_off && !cbe_n[0]) begin
                int_en    <= ad_in[`PDTB_INTEN_BIT];
                core_srst <= ad_in[`PDTB_SRST_BIT];
              end
            end else if (!is_cfg) begin
              rd_ready <= 1'b0;
            end
            if (frame_n) begin
              stop_n_out   <= 1'b1;
              devsel_n_out <= 1'b1;
              state        <= S_TURN;
            end else begin
              state <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (frame_n) begin
            stop_n_out   <= 1'b1;
            devsel_n_out <= 1'b1;
            state        <= S_TURN;
          end
        end
        S_TURN: begin
          tgt_oe <= 1'b0;
          state  <= S_IDLE;
        end
        S_BUSY: begin
          if (frame_n && irdy_n)
            state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
      if (perr)
        det_perr <= 1'b1;
    end
  end

  pdtb_parity u_parity (
    .clk     (clk),
    .rst_b   (rst_b),
    .ad_in   (ad_in),
    .cbe_n   (cbe_n),
    .par_in  (par_in),
    .ad_out  (ad_out),
    .ad_oe   (ad_oe),
    .chk     (chk),
    .par_out (par_out),
    .par_oe  (par_oe),
    .perr    (perr)
  );

  pdtb_xfer_timer #(
    .CW     (`PDTB_TMR_W),
    .CYCLES (XFER_CYC[`PDTB_TMR_W-1:0])
  ) u_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .start (tmr_start),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

endmodule // pdtb_target

// ==== test/pdtb_target_assertions.sv ====
`timescale 1ns/1ps

module pdtb_target_assertions (
  // Clock and reset
  input wire        clk,
  input wire        rst_b,
  // Bus side
  input wire        frame_n,
  input wire        irdy_n,
  input wire [31:0] ad_in,
  input wire [3:0]  cbe_n,
  input wire        ad_oe,
  input wire        devsel_n_out,
  input wire        trdy_n_out,
  input wire        stop_n_out,
  input wire        tgt_oe,
  input wire        inta_n_out,
  input wire        inta_n_oe,
  // Core side
  input wire [9:0]  core_addr,
  input wire        core_wr,
  input wire        core_rd,
  input wire        core_irq
);
  reg        fr_q;
  reg [3:0]  cmd_q;
  reg [11:0] adr_q;
  reg [3:0]  since_rd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Command and address of the transaction in flight
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fr_q     <= 1'b1;
      cmd_q    <= 4'h0;
      adr_q    <= 12'h000;
      since_rd <= 4'hF;
    end else begin
      fr_q <= frame_n;
      if (!frame_n && fr_q) begin
        cmd_q <= cbe_n;
        adr_q <= ad_in[11:0];
      end
      if (core_rd)
        since_rd <= 4'h0;
      else if (since_rd != 4'hF)
        since_rd <= since_rd + 4'h1;
    end
  end

  sequence s_addr;
    !frame_n && fr_q;
  endsequence
  sequence s_abort;
    tgt_oe && !devsel_n_out ##1 tgt_oe && devsel_n_out && !stop_n_out;
  endsequence

  property p_no_claim;
    s_addr ##0 (cbe_n[3:1] != 3'h3 && cbe_n[3:1] != 3'h5) |=>
      (devsel_n_out || !tgt_oe) [*4];
  endproperty
  a_no_claim: assert property (p_no_claim) else $error("unclaimed answered");
  property p_rd_retry;
    core_rd |-> ##[0:1] (tgt_oe && !stop_n_out && trdy_n_out);
  endproperty
  a_rd_retry: assert property (p_rd_retry) else $error("fetch not retried");
  property p_rd_wait;
    $rose(ad_oe) && cmd_q == 4'h6 && adr_q[11:2] != 10'h000 |->
      since_rd >= 4'hA;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("data before fetch");
  property p_wr_post;
    tgt_oe && !trdy_n_out && !irdy_n && cmd_q == 4'h7 && adr_q[11:2] != 0
      |-> ##[1:2] (core_wr && core_addr == adr_q[11:2]);
  endproperty
  a_wr_post: assert property (p_wr_post) else $error("write not posted");
  property p_busy;
    core_wr |=> (trdy_n_out || !tgt_oe || cmd_q[3]) [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("accepted while busy");
  property p_abort;
    s_abort |-> adr_q[1:0] != 2'h0;
  endproperty
  a_abort: assert property (p_abort) else $error("abort on aligned");
  property p_inta;
    inta_n_oe |-> !inta_n_out && $past(core_irq);
  endproperty
  a_inta: assert property (p_inta) else $error("INTA without cause");
  property p_inta_hold;
    $fell(inta_n_oe) |-> !$past(core_irq) ||
      (cmd_q == 4'h7 && adr_q[11:2] == 10'h000);
  endproperty
  a_inta_hold: assert property (p_inta_hold) else $error("INTA dropped");
endmodule // pdtb_target_assertions

bind pdtb_target pdtb_target_assertions i_chk (.*);

// ==== test/pdtb_host_model.sv ====
`timescale 1ns/1ps

module pdtb_host_model (
  // Clock
  input  wire        clk,
  // Resolved bus lines
  input  wire [31:0] ad,
  input  wire        devsel_n,
  input  wire        trdy_n,
  input  wire        stop_n,
  input  wire        tgt_oe,
  // Initiator drives
  output reg         frame_n,
  output reg         irdy_n,
  output reg         idsel,
  output reg  [31:0] m_ad,
  output reg  [3:0]  cbe_n,
  output reg         par
);
  reg     bad;
  integer n;

  initial begin
    frame_n = 1'b1;
    irdy_n  = 1'b1;
    idsel   = 1'b0;
    m_ad    = 32'h0000_0000;
    cbe_n   = 4'hF;
    par     = 1'b0;
    bad     = 1'b0;
  end

  // Even parity trails its phase by one clock
  always @(posedge clk)
    par <= ^{ad, cbe_n} ^ bad;

  // One dword; term 0 data, 1 retry, 2 abort, 3 unclaimed
  task xact(input [3:0] cmd, input [31:0] addr, input [31:0] wdata,
            input bp, output integer term, output [31:0] rdata);
    begin
      term = 3;
      rdata = 32'h0;
      n = 0;
      frame_n <= 1'b0;
      idsel <= !cmd[2];
      m_ad <= addr;
      cbe_n <= cmd;
      @(posedge clk);
      frame_n <= 1'b1;
      irdy_n <= 1'b0;
      idsel <= 1'b0;
      cbe_n <= 4'h0;
      m_ad <= cmd[0] ? wdata : ~addr;
      bad <= bp;
      while (term == 3 && n < 8) begin
        @(posedge clk);
        n = n + 1;
        rdata = ad;
        if (!trdy_n)
          term = 0;
        else if (!stop_n)
          term = devsel_n ? 2 : 1;
      end
      irdy_n <= 1'b1;
      bad <= 1'b0;
      // Released lines must not keep their last value
      m_ad <= ~m_ad;
      // One idle clock so an unclaimed cycle sees FRAME# and IRDY# high
      @(posedge clk);
      n = 0;
      while (tgt_oe && n < 8) begin
        @(posedge clk);
        n = n + 1;
      end
    end
  endtask
endmodule // pdtb_host_model

// ==== test/pdtb_target_test.sv ====
`timescale 1ns/1ps

module pdtb_target_test;
  localparam [15:0] VEN  = 16'h1234; // Arbitrary value
  localparam [15:0] DEV  = 16'h4321; // Arbitrary value
  localparam [31:0] BASE = 32'h8765_3000;
  reg         clk, rst_b, core_irq, exp_par;
  reg  [31:0] core_rdata, rd, wd, wr_data;
  reg  [9:0]  off, wr_addr;
  reg  [3:0]  wr_be;
  wire        frame_n, irdy_n, idsel, m_par, par_out, par_oe, ad_oe;
  wire        devsel_n_out, trdy_n_out, stop_n_out, tgt_oe;
  wire        perr_n_out, perr_n_oe, inta_n_out, inta_n_oe;
  wire        core_wr, core_rd, core_srst;
  wire [31:0] m_ad, ad_out, core_wdata;
  wire [3:0]  cbe_n, core_be;
  wire [9:0]  core_addr;
  integer     error_cnt, checks_done, seed, cyc, i, term, srst_cnt, perr_cnt;
  // Pulled-up lines read high when nobody drives them
  wire [31:0] ad = ad_oe ? ad_out : m_ad;
  wire        par = par_oe ? par_out : m_par;
  wire        devsel_n = tgt_oe ? devsel_n_out : 1'b1;
  wire        trdy_n = tgt_oe ? trdy_n_out : 1'b1;
  wire        stop_n = tgt_oe ? stop_n_out : 1'b1;
  wire        inta_n = inta_n_oe ? inta_n_out : 1'b1;

  pdtb_target #(.VENDOR_ID(VEN), .DEVICE_ID(DEV)) i_dut (
    .clk(clk), .rst_b(rst_b), .frame_n(frame_n), .irdy_n(irdy_n),
    .idsel(idsel), .ad_in(ad), .cbe_n(cbe_n), .par_in(par),
    .ad_out(ad_out), .ad_oe(ad_oe), .par_out(par_out), .par_oe(par_oe),
    .devsel_n_out(devsel_n_out), .trdy_n_out(trdy_n_out),
    .stop_n_out(stop_n_out), .tgt_oe(tgt_oe), .perr_n_out(perr_n_out),
    .perr_n_oe(perr_n_oe), .inta_n_out(inta_n_out), .inta_n_oe(inta_n_oe),
    .core_addr(core_addr), .core_wdata(core_wdata), .core_be(core_be),
    .core_wr(core_wr), .core_rd(core_rd), .core_rdata(core_rdata),
    .core_irq(core_irq), .core_srst(core_srst));

  pdtb_host_model i_host (
    .clk(clk), .ad(ad), .devsel_n(devsel_n), .trdy_n(trdy_n),
    .stop_n(stop_n), .tgt_oe(tgt_oe), .frame_n(frame_n), .irdy_n(irdy_n),
    .idsel(idsel), .m_ad(m_ad), .cbe_n(cbe_n), .par(m_par));

  function [31:0] dat_of(input [9:0] a);
    dat_of = {~a, 12'h5A3, a};
  endfunction

  task check(input [95:0] what, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task mem(input [3:0] cmd, input [9:0] o, input [31:0] d, input bp);
    i_host.xact(cmd, BASE | {20'h0, o, 2'h0}, d, bp, term, rd);
  endtask

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  always #50 clk = ~clk;

  // Core model, strobe capture and run limit
  always @(posedge clk) begin
    core_rdata <= dat_of(core_addr);
    cyc = cyc + 1;
    if (core_wr) begin
      wr_addr <= core_addr;
      wr_data <= core_wdata;
      wr_be <= core_be;
    end
    if (core_srst)
      srst_cnt = srst_cnt + 1;
    if (perr_n_oe)
      perr_cnt = perr_cnt + 1;
    // Read parity trails its data phase by one clock
    if (par_oe)
      check("par_out", {31'h0, par_out}, {31'h0, exp_par});
    exp_par <= ^{ad, cbe_n};
    if (cyc == 4000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    core_irq = 1'b0;
    core_rdata = 32'h0;
    {error_cnt, checks_done, cyc, srst_cnt, perr_cnt} = 0;
    seed = 32'h35274D99;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    i_host.xact(4'hA, 32'h0, 32'h0, 1'b0, term, rd);
    check("cfg_id", rd, {DEV, VEN});
    i_host.xact(4'hB, 32'h10, 32'hFFFF_FFFF, 1'b0, term, rd);
    i_host.xact(4'hA, 32'h10, 32'h0, 1'b0, term, rd);
    check("bar", rd, 32'hFFFF_F000);
    i_host.xact(4'hB, 32'h10, BASE, 1'b0, term, rd);
    i_host.xact(4'hB, 32'h4, 32'h0000_0042, 1'b0, term, rd);
    i_host.xact(4'h2, BASE, 32'h0, 1'b0, term, rd);
    check("io_term", term, 3);
    i_host.xact(4'h6, BASE | 32'h1, 32'h0, 1'b0, term, rd);
    check("abort", term, 2);
    $display("decode test done");
    for (i = 0; i < 5; i = i + 1) begin
      // Even offsets so off+1 never wraps to offset zero
      wd = $random(seed);
      off = (i == 0) ? 10'h3FE : {wd[8:0] | 9'h001, 1'b0};
      mem(4'h6, off, 32'h0, 1'b0);
      check("rd_first", term, 1);
      mem(4'h6, off, 32'h0, 1'b0);
      check("rd_busy", term, 1);
      repeat (14) @(posedge clk);
      mem(4'h6, off + 10'h1, 32'h0, 1'b0);
      check("rd_other", term, 1);
      repeat (14) @(posedge clk);
      mem(4'h6, off + 10'h1, 32'h0, 1'b0);
      check("rd_term", term, 0);
      check("rd_data", rd, dat_of(off + 10'h1));
    end
    $display("delayed read test done");
    for (i = 0; i < 3; i = i + 1) begin
      rd = $random(seed);
      off = rd[9:0] | 10'h001;
      wd = $random(seed);
      repeat (14) @(posedge clk);
      mem(4'h7, off, wd, 1'b0);
      check("wr_term", term, 0);
      mem(4'h7, off ^ 10'h2, ~wd, 1'b0);
      check("wr_busy", term, 1);
      mem(4'h6, off, 32'h0, 1'b0);
      check("rd_order", term, 1);
      check("wr_addr", {22'h0, wr_addr}, {22'h0, off});
      check("wr_data", wr_data, wd);
      check("wr_be", {28'h0, wr_be}, 32'hF);
      repeat (14) @(posedge clk);
      mem(4'h7, off ^ 10'h2, ~wd, 1'b0);
      check("wr_again", term, 0);
    end
    $display("posted write test done");
    check("perr_none", perr_cnt, 0);
    repeat (14) @(posedge clk);
    mem(4'h7, 10'h005, 32'h0F0F_0F0F, 1'b1);
    repeat (4) @(posedge clk);
    check("perr", perr_cnt, 1);
    repeat (14) @(posedge clk);
    core_irq <= 1'b1;
    mem(4'h7, 10'h000, 32'h1, 1'b0);
    repeat (14) @(posedge clk);
    check("inta_on", {31'h0, inta_n}, 0);
    mem(4'h7, 10'h000, 32'h3, 1'b0);
    repeat (14) @(posedge clk);
    check("srst", srst_cnt, 1);
    check("inta_kept", {31'h0, inta_n}, 0);
    core_irq <= 1'b0;
    repeat (3) @(posedge clk);
    check("inta_off", {31'h0, inta_n}, 1);
    core_irq <= 1'b1;
    mem(4'h7, 10'h000, 32'h0, 1'b0);
    repeat (14) @(posedge clk);
    check("inta_mask", {31'h0, inta_n}, 1);
    $display("parity and interrupt test done");
    wrap_up;
  end
endmodule // pdtb_target_test
